// ---- rtl/nvram_cmd_guard.v ----
// Behaviour
// - Latch-set opcode sets the write-enable latch.
// - Latch-clear opcode clears the latch, blocking writes.
// - Status read shifts out one byte of status.
// - Status write updates only pin-enable and block-guard bits when permitted.
// - Read, fast read and memory write opcodes decoded exactly.
// - Sleep, ident and serial number opcodes decoded; ten commands.
// - Latch is clear after reset.
// - Status write data never changes the latch bit.
// - Select rise after clear, status write or memory write clears latch.
// - Bits 0,4,5 read zero; bit 6 reads one.
// - Bit 1 shows the write-enable latch.
// - Block-guard bits held in guard_nv_q, cleared to zero by reset.
// - Guard pair protects none, top quarter, upper half or all.
// - Pin-enable gates guard pin; low pin blocks status writes.
// - Guard pin never blocks array writes.
// - Write takes three address bytes, low 17 bits, data MSB first.
// - Address increments per byte and wraps top to zero.
// - Select rise ends a write.
// - At a protected address, increment stops and later data are ignored.
// - Each byte commits at its eighth bit, no busy state.
// - Unknown opcode ignored with the rest of the frame, output off.
// - First byte after select fall is the only opcode.
// - Sample on rising clock, change output on falling clock, MSB first.
// - While deselected input is ignored and output is off.
// File: serial memory command decoder with write guard, top module.
// Assumes the serial pins arrive asynchronously; the array write port is
// an external store that accepts a word when wr_valid and wr_ready are high.
`timescale 1ns/1ps
`default_nettype none
`include "nvram_cmd_defines.vh"
module nvram_cmd_guard (
  input wire core_clk,
  input wire rst,
  input wire sck,
  input wire cs_n,
  input wire si,
  input wire write_guard_n,
  output reg so_out,
  output reg so_oe,
  output reg [16:0] wr_addr,
  output reg [7:0] wr_data,
  output reg wr_valid,
  input wire wr_ready,
  output reg [1:0] guard_nv_q,
  output reg guard_pin_enable_q,
  output reg sleep_req,
  output reg [7:0] last_opcode
);
  ////////////////////////////////////////////////////////////////////////////
  // States of the frame decoder.
  localparam S_IDLE = 6'b000001;
  localparam S_OPC = 6'b000010;
  localparam S_ADDR = 6'b000100;
  localparam S_DATA = 6'b001000;
  localparam S_STWR = 6'b010000;
  localparam S_SKIP = 6'b100000;

  // Decodes the opcode into a known command.
  function is_known;
    input [7:0] op;
    begin
      case (op)
        `OP_LATCH_SET, `OP_LATCH_CLR, `OP_STAT_RD, `OP_STAT_WR,
        `OP_MEM_RD, `OP_FAST_RD, `OP_MEM_WR, `OP_SLEEP,
        `OP_IDENT_RD, `OP_SERIAL_RD: is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  // Reports whether an address lies in the guarded region.
  function is_guarded;
    input [1:0] bg;
    input [16:0] a;
    begin
      case (bg)
        2'b01: is_guarded = (a >= `ADDR_QUARTER);
        2'b10: is_guarded = (a >= `ADDR_HALF);
        2'b11: is_guarded = 1'b1;
        default: is_guarded = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  wire [3:0] pins_s;
  pin_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in({sck, cs_n, si, write_guard_n}),
    .pin_out(pins_s)
  );
  wire sck_s = pins_s[3];
  wire cs_s = pins_s[2];
  wire si_s = pins_s[1];
  wire wg_s = pins_s[0];
  reg sck_q;
  reg cs_q;
  always @(posedge core_clk) begin
    if (rst) begin
      sck_q <= 1'b1;
      cs_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      cs_q <= cs_s;
    end
  end
  wire sck_rise = sck_s && !sck_q && !cs_s;
  wire sck_fall = !sck_s && sck_q && !cs_s;
  wire cs_fall = !cs_s && cs_q;
  wire cs_rise = cs_s && !cs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder and status register.
  reg [5:0] state_q;
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  reg [1:0] abyte_q;
  reg [16:0] addr_q;
  reg [7:0] op_q;
  reg wel_q;
  reg halt_q;
  reg stat_rd_q;
  reg [7:0] tx_q;
  wire [7:0] sh_next = {sh_q[6:0], si_s};
  wire byte_done = sck_rise && (bit_q == 3'd7);
  wire [7:0] status_rd = `ST_FIXED | {guard_pin_enable_q, 3'b000,
    guard_nv_q, wel_q, 1'b0};
  wire stat_guard = guard_pin_enable_q && !wg_s;

  wire buf_in_ready;
  reg buf_in_valid;
  reg [24:0] buf_in_data;
  wire buf_out_valid;
  wire [24:0] buf_out_data;

  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      abyte_q <= 2'd0;
      addr_q <= 17'h00000;
      op_q <= 8'h00;
      wel_q <= 1'b0;
      halt_q <= 1'b0;
      stat_rd_q <= 1'b0;
      tx_q <= 8'hff;
      guard_nv_q <= `GUARD_RESET;
      guard_pin_enable_q <= 1'b0;
      buf_in_valid <= 1'b0;
      buf_in_data <= 25'h0;
      sleep_req <= 1'b0;
      last_opcode <= 8'h00;
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      if (buf_in_valid && buf_in_ready) begin
        buf_in_valid <= 1'b0;
      end
      if (cs_s) begin
        so_oe <= 1'b0;
      end else if (sck_fall && stat_rd_q) begin
        so_oe <= 1'b1;
        so_out <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b1};
      end
      if (cs_fall) begin
        state_q <= S_OPC;
        bit_q <= 3'd0;
        stat_rd_q <= 1'b0;
        sleep_req <= 1'b0;
      end else if (cs_rise) begin
        state_q <= S_IDLE;
        stat_rd_q <= 1'b0;
        so_oe <= 1'b0;
        if (op_q == `OP_LATCH_CLR || op_q == `OP_STAT_WR || op_q == `OP_MEM_WR) begin
          wel_q <= 1'b0;
        end
        if (op_q == `OP_SLEEP) begin
          sleep_req <= 1'b1;
        end
        op_q <= 8'h00;
      end else if (sck_rise) begin
        sh_q <= sh_next;
        bit_q <= bit_q + 3'd1;
        case (state_q)
          S_OPC: begin
            if (byte_done) begin
              op_q <= sh_next;
              last_opcode <= sh_next;
              abyte_q <= 2'd0;
              halt_q <= 1'b0;
              if (!is_known(sh_next)) begin
                state_q <= S_SKIP;
              end else begin
                case (sh_next)
                  `OP_LATCH_SET: begin
                    wel_q <= 1'b1;
                    state_q <= S_SKIP;
                  end
                  `OP_LATCH_CLR: begin
                    wel_q <= 1'b0;
                    state_q <= S_SKIP;
                  end
                  `OP_STAT_RD: begin
                    stat_rd_q <= 1'b1;
                    tx_q <= status_rd;
                    state_q <= S_SKIP;
                  end
                  `OP_STAT_WR: state_q <= S_STWR;
                  `OP_MEM_WR: state_q <= S_ADDR;
                  default: state_q <= S_SKIP;
                endcase
              end
            end
          end
          S_ADDR: begin
            if (byte_done) begin
              addr_q <= {addr_q[8:0], sh_next};
              abyte_q <= abyte_q + 2'd1;
              if (abyte_q == 2'd2) begin
                state_q <= S_DATA;
                halt_q <= is_guarded(guard_nv_q, {addr_q[8:0], sh_next});
              end
            end
          end
          S_DATA: begin
            if (byte_done && !halt_q && wel_q && buf_in_ready) begin
              buf_in_valid <= 1'b1;
              buf_in_data <= {addr_q, sh_next};
              addr_q <= (addr_q == `ADDR_TOP) ? 17'h00000 : addr_q + 17'h1;
              halt_q <= is_guarded(guard_nv_q,
                (addr_q == `ADDR_TOP) ? 17'h00000 : addr_q + 17'h1);
            end
          end
          S_STWR: begin
            if (byte_done) begin
              state_q <= S_SKIP;
              if (wel_q && !stat_guard) begin
                guard_pin_enable_q <= sh_next[`ST_PIN_EN_BIT];
                guard_nv_q <= {sh_next[`ST_BG_HI_BIT], sh_next[`ST_BG_LO_BIT]};
              end
            end
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write buffer toward the store.
  skid_buf2 #(.W(25)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(wr_ready && !wr_valid),
    .out_data(buf_out_data)
  );

  always @(posedge core_clk) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_addr <= 17'h00000;
      wr_data <= 8'h00;
    end else if (wr_valid) begin
      wr_valid <= 1'b0;
    end else if (buf_out_valid && wr_ready) begin
      wr_valid <= 1'b1;
      wr_addr <= buf_out_data[24:8];
      wr_data <= buf_out_data[7:0];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/nvram_cmd_defines.vh ----
// Constants of the serial memory command decoder and write guard.
// Assumes inclusion by bare name from the design files.
`ifndef NVRAM_CMD_DEFINES_VH
`define NVRAM_CMD_DEFINES_VH
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLR 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_MEM_RD 8'h03
`define OP_FAST_RD 8'h0b
`define OP_MEM_WR 8'h02
`define OP_SLEEP 8'hb9
`define OP_IDENT_RD 8'h9f
`define OP_SERIAL_RD 8'hc3
`define ST_WEL_BIT 1
`define ST_BG_LO_BIT 2
`define ST_BG_HI_BIT 3
`define ST_ONE_BIT 6
`define ST_PIN_EN_BIT 7
`define ST_FIXED 8'h40
`define ST_WR_MASK 8'h8c
`define ADDR_W 17
`define ADDR_QUARTER 17'h18000
`define ADDR_HALF 17'h10000
`define ADDR_TOP 17'h1ffff
`define GUARD_RESET 2'h0
`endif

// ---- rtl/pin_sync.v ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 4
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] pin_in,
  output reg [W-1:0] pin_out
);
  reg [W-1:0] meta_q;
  always @(posedge core_clk) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      pin_out <= {W{1'b1}};
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/skid_buf2.v ----
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink on core_clk.
`timescale 1ns/1ps
`default_nettype none
module skid_buf2 #(
  parameter W = 25
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] slot_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 2'd0;
      slot_q <= {W{1'b0}};
      out_data <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (push) begin
        if (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) begin
          out_data <= in_data;
        end else begin
          slot_q <= in_data;
        end
      end
      if (pop && cnt_q == 2'd2) begin
        out_data <= slot_q;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/nvram_cmd_guard_chk.sv ----
// Checker for the serial memory command decoder and write guard.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "nvram_cmd_defines.vh"
module nvram_cmd_guard_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic write_guard_n,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic [16:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [1:0] guard_nv_q,
  input wire logic guard_pin_enable_q,
  input wire logic sleep_req,
  input wire logic [7:0] last_opcode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic seen_q;
  logic [16:0] last_q;
  function automatic logic prot(input logic [16:0] a, input logic [1:0] g);
    case (g)
      2'b01: prot = a >= `ADDR_QUARTER;
      2'b10: prot = a >= `ADDR_HALF;
      2'b11: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction
  always @(posedge core_clk) begin
    if (rst || cs_n) seen_q <= 1'b0;
    else if (wr_valid) seen_q <= 1'b1;
    if (wr_valid) last_q <= wr_addr;
  end
  //////////////////////////////
  sequence pin_low_s;
    (guard_pin_enable_q && !write_guard_n) [*6];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !so_oe && !wr_valid)
    else $error("outputs active after reset");
  oe_idle_a: assert property (cs_n [*8] |-> !so_oe)
    else $error("output driven while deselected");
  oe_cmd_a: assert property ($rose(so_oe) |-> last_opcode inside {`OP_STAT_RD, `OP_MEM_RD,
    `OP_FAST_RD, `OP_IDENT_RD, `OP_SERIAL_RD})
    else $error("output driven after a non-read opcode");
  wr_pulse_a: assert property (wr_valid |=> !wr_valid)
    else $error("write strobe longer than one cycle");
  wr_cmd_a: assert property (wr_valid |-> last_opcode == `OP_MEM_WR)
    else $error("array write outside a write command");
  addr_step_a: assert property (wr_valid && seen_q |-> wr_addr == last_q + 17'h00001)
    else $error("burst address did not step by one");
  guard_range_a: assert property (wr_valid |-> !prot(wr_addr, guard_nv_q))
    else $error("write to a guarded address");
  pin_block_a: assert property (pin_low_s |=> $stable(guard_nv_q) && guard_pin_enable_q)
    else $error("status changed while the guard pin blocks it");
  sleep_rise_a: assert property ($rose(sleep_req) |-> last_opcode == `OP_SLEEP && cs_n)
    else $error("sleep request without the sleep opcode");
endmodule
bind nvram_cmd_guard nvram_cmd_guard_chk u_nvram_cmd_guard_chk (.core_clk(core_clk), .rst(rst),
  .sck(sck), .cs_n(cs_n), .si(si), .write_guard_n(write_guard_n), .so_out(so_out),
  .so_oe(so_oe), .wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .guard_nv_q(guard_nv_q), .guard_pin_enable_q(guard_pin_enable_q),
  .sleep_req(sleep_req), .last_opcode(last_opcode));
`default_nettype wire

// ---- dv/spi_host.sv ----
// Serial bus master model in mode 0 or mode 3, most significant bit first.
// Assumes core_clk at 8 ns; the serial clock runs at 80 ns inside frames only.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input wire logic core_clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [7:0] rx;
  logic mode3 = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx = 8'h00;
  end
  task automatic half;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic start;
    sck = mode3;
    half();
    cs_n = 1'b0;
    half();
  endtask
  task automatic stop;
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask
  task automatic xbyte(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      if (mode3) sck = 1'b0;
      si = tx[i];
      half();
      sck = 1'b1;
      rx = {rx[6:0], so_oe ? so_out : 1'bz};
      half();
      if (!mode3) sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the serial memory command decoder and write guard.
// Assumes the bound checker and the master model in spi_host.
`timescale 1ns/1ps
`default_nettype none
`include "nvram_cmd_defines.vh"
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic write_guard_n = 1'b1;
  logic wr_ready = 1'b1;
  wire sck, cs_n, si, so_out, so_oe, wr_valid, guard_pin_enable_q, sleep_req;
  wire [16:0] wr_addr;
  wire [7:0] wr_data, last_opcode;
  wire [1:0] guard_nv_q;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [24:0] got[$];
  logic [7:0] ops[10] = '{`OP_LATCH_SET, `OP_LATCH_CLR, `OP_STAT_RD, `OP_STAT_WR, `OP_MEM_RD,
    `OP_FAST_RD, `OP_MEM_WR, `OP_SLEEP, `OP_IDENT_RD, `OP_SERIAL_RD};
  always #4 core_clk = ~core_clk;
  spi_host u_spi_host (.core_clk(core_clk), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe(so_oe));
  nvram_cmd_guard u_nvram_cmd_guard (.core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n),
    .si(si), .write_guard_n(write_guard_n), .so_out(so_out), .so_oe(so_oe), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .guard_nv_q(guard_nv_q),
    .guard_pin_enable_q(guard_pin_enable_q), .sleep_req(sleep_req), .last_opcode(last_opcode));
  //////////////////////////////
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (wr_valid === 1'b1 && wr_ready) got.push_back({wr_addr, wr_data});
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    u_spi_host.start();
    u_spi_host.xbyte(op);
    u_spi_host.stop();
  endtask
  task automatic rd_stat(input logic [7:0] exp);
    u_spi_host.start();
    u_spi_host.xbyte(`OP_STAT_RD);
    u_spi_host.xbyte(8'hff);
    u_spi_host.stop();
    check("status", u_spi_host.rx, exp);
  endtask
  task automatic wr_st(input logic [7:0] v);
    cmd(`OP_LATCH_SET);
    u_spi_host.start();
    u_spi_host.xbyte(`OP_STAT_WR);
    u_spi_host.xbyte(v);
    u_spi_host.stop();
  endtask
  task automatic mem_wr(input logic [16:0] a, input int n, input bit set);
    if (set) cmd(`OP_LATCH_SET);
    u_spi_host.start();
    u_spi_host.xbyte(`OP_MEM_WR);
    u_spi_host.xbyte({7'h00, a[16]});
    u_spi_host.xbyte(a[15:8]);
    u_spi_host.xbyte(a[7:0]);
    for (int i = 0; i < n; i++) u_spi_host.xbyte(8'ha0 + 8'(i));
    u_spi_host.stop();
  endtask
  task automatic chk_wr(input int n, input logic [16:0] a);
    repeat (8) @(posedge core_clk);
    check("count", got.size(), n);
    for (int i = 0; i < n; i++) check("word", got[i], {a + 17'(i), 8'ha0 + 8'(i)});
    got.delete();
  endtask
  //////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    rd_stat(8'h40);
    cmd(`OP_LATCH_SET);
    rd_stat(8'h42);
    cmd(`OP_LATCH_CLR);
    rd_stat(8'h40);
    wr_st(8'hff);
    rd_stat(8'hcc);
    check("guard", guard_nv_q, 2'b11);
    write_guard_n = 1'b0;
    wr_st(8'h00);
    rd_stat(8'hcc);
    write_guard_n = 1'b1;
    wr_st(8'h84);
    rd_stat(8'hc4);
    write_guard_n = 1'b0;
    mem_wr(17'h17ffe, 4, 1'b1);
    chk_wr(2, 17'h17ffe);
    write_guard_n = 1'b1;
    wr_st(8'h00);
    mem_wr(17'h1fffe, 3, 1'b1);
    chk_wr(3, 17'h1fffe);
    rd_stat(8'h40);
    mem_wr(17'h00010, 2, 1'b0);
    chk_wr(0, 17'h00010);
    wr_st(8'h08);
    mem_wr(17'h0ffff, 2, 1'b1);
    chk_wr(1, 17'h0ffff);
    wr_st(8'h0c);
    mem_wr(17'h00000, 1, 1'b1);
    chk_wr(0, 17'h00000);
    wr_st(8'h00);
    wr_ready = 1'b0;
    mem_wr(17'h00123, 1, 1'b1);
    wr_ready = 1'b1;
    chk_wr(1, 17'h00123);
    cmd(8'h55);
    rd_stat(8'h40);
    u_spi_host.mode3 = 1'b1;
    cmd(`OP_LATCH_SET);
    rd_stat(8'h42);
    mem_wr(17'h00200, 2, 1'b1);
    chk_wr(2, 17'h00200);
    u_spi_host.mode3 = 1'b0;
    for (int i = 0; i < 10; i++) begin
      cmd(ops[i]);
      check("opcode", last_opcode, ops[i]);
      check("sleep", sleep_req, ops[i] == `OP_SLEEP);
    end
    results();
  end
endmodule
`default_nettype wire
